// [logic/shaping_pkg.sv]
/*
 Shared constants, types and the dead-time code conversion for the
 timer output shaping block.
 Assumes a single kernel clock and word-wide register accesses.
*/
// Operation
// - Bit 28 enables composite PWM, channel 0
// - Bits 31..29 enable composite PWM, channels 3..1
// - Additional compare acts only in composite PWM
// - Two-bit pair select per channel, bits 27:20
// - Pair select 00 keeps channels independent
// - Pair select 11 drives paired output complemented
// - Bit 19 enables quadrature signal loss detect
// - Bit 18 enables quadrature double toggle detect
// - Match pulse select 00 keeps normal reference
// - Select 01 pulses one cycle when up-counting
// - Select 10 pulses one cycle when down-counting
// - Select 11 pulses one cycle both directions
// - Bits 7..4 enable break per channel
// - Bits 3..0 enable dead-time per channel
// - Override bit 31 selects channel 0 settings
// - Override bits 23:16 give falling-edge dead time
// - Override lock-field writes ignored unless level 00
// - Code 0xx gives code times one tick
// - Code 10x gives (64+low6) times two ticks
// - Code 110 gives (32+low5) times eight ticks
// - Code 111 gives (32+low5) times sixteen ticks
`default_nettype none

package shaping_pkg;

    localparam int          NUM_CH         = 4;
    localparam logic [7:0]  CTL_OFFSET     = 8'h74;
    localparam logic [7:0]  OVR_OFFSET     = 8'h7C;
    localparam logic [31:0] CTL_RESET      = 32'h0FF0_00FF;
    localparam logic [31:0] OVR_RESET      = 32'h0000_0000;
    localparam logic [31:0] CTL_WMASK      = 32'hFFFC_FFFF;
    localparam logic [31:0] OVR_OPEN_MASK  = 32'h80FF_00FF;
    localparam logic [31:0] OVR_STATE_MASK = 32'h0000_0C00;
    localparam int          CPWM_LSB       = 28;
    localparam int          PSEL_LSB       = 20;
    localparam int          QLOSS_BIT      = 19;
    localparam int          QJUMP_BIT      = 18;
    localparam int          MPSEL_LSB      = 8;
    localparam int          BRK_LSB        = 4;
    localparam int          DTI_LSB        = 0;
    localparam int          OVR_SEL_BIT    = 31;
    localparam int          OVR_FALL_LSB   = 16;
    localparam int          OVR_ROS_BIT    = 11;
    localparam int          OVR_IOS_BIT    = 10;
    localparam int          OVR_RISE_LSB   = 0;
    localparam logic [1:0]  PROT_OPEN      = 2'h0;
    localparam int          DT_W           = 11;
    localparam logic [10:0] DT_BASE_64     = 11'h040;
    localparam logic [10:0] DT_BASE_32     = 11'h020;
    localparam logic [10:0] DT_ONE         = 11'h001;

    typedef enum logic [1:0] {
        PAIR_INDEP = 2'h0,
        PAIR_RSV1  = 2'h1,
        PAIR_RSV2  = 2'h2,
        PAIR_COMP  = 2'h3
    } pair_mode_t;

    typedef enum logic [1:0] {
        MP_NORMAL = 2'h0,
        MP_UP     = 2'h1,
        MP_DOWN   = 2'h2,
        MP_BOTH   = 2'h3
    } match_pulse_t;

    // Gray order along low -> rise wait -> high -> fall wait
    typedef enum logic [1:0] {
        ST_LOW       = 2'h0,
        ST_RISE_WAIT = 2'h1,
        ST_HIGH      = 2'h3,
        ST_FALL_WAIT = 2'h2
    } dt_state_t;

    // Dead-time code to count of dead-time ticks
    function automatic logic [10:0] dt_ticks(input logic [7:0] code);
        logic [10:0] t;
        t = 11'h000;
        casez (code[7:5])
            3'b0??:  t = {3'h0, code};
            3'b10?:  t = (DT_BASE_64 + {5'h00, code[5:0]}) << 1;
            3'b110:  t = (DT_BASE_32 + {6'h00, code[4:0]}) << 3;
            default: t = (DT_BASE_32 + {6'h00, code[4:0]}) << 4;
        endcase
        return t;
    endfunction

endpackage

`default_nettype wire

// [logic/chan_if.sv]
/*
 Per-channel link between the top level and a dead-time unit.
 Assumes one instance per channel, all on the kernel clock.
*/
`timescale 1ns/1ps
`default_nettype none

interface chan_if;
    logic        ref_in;
    logic        pair_ref;
    logic        comp;
    logic        dt_en;
    logic        brk;
    logic        tick;
    logic [10:0] rise_ticks;
    logic [10:0] fall_ticks;
    logic        pri;
    logic        pair;

    modport unit (input ref_in, pair_ref, comp, dt_en, brk, tick,
                  input rise_ticks, fall_ticks, output pri, pair);
    modport ctrl (output ref_in, pair_ref, comp, dt_en, brk, tick,
                  output rise_ticks, fall_ticks, input pri, pair);
endinterface

`default_nettype wire

// [logic/reference_shaper.sv]
/*
 Builds one channel's reference: normal, composite, or match pulse.
 Assumes match and add_match are one-cycle strobes from compare logic.
*/
`timescale 1ns/1ps
`default_nettype none

module reference_shaper
    import shaping_pkg::*;
(
    input  wire logic   clk_sys,
    input  wire logic   rst,
    input  wire logic   normal_ref,
    input  wire logic   match,
    input  wire logic   add_match,
    input  wire logic   count_down,
    input  wire logic   composite_en,
    input  wire match_pulse_t sel,
    output logic        ref_out
);
    logic comp_r;
    logic comp_nxt;
    logic ref_r;
    logic ref_nxt;

    ////////////////////////////////////////////////////////////////////////
    // Composite level set by main match, cleared by additional match
    always_comb
    begin
        comp_nxt = 1'b0;
        if (composite_en)
            comp_nxt = match ? 1'b1 : (add_match ? 1'b0 : comp_r);
        case (sel)
            MP_UP:   ref_nxt = match && !count_down;
            MP_DOWN: ref_nxt = match && count_down;
            MP_BOTH: ref_nxt = match;
            default: ref_nxt = composite_en ? comp_nxt : normal_ref;
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            comp_r <= 1'b0;
            ref_r  <= 1'b0;
        end
        else
        begin
            comp_r <= comp_nxt;
            ref_r  <= ref_nxt;
        end
    end

    assign ref_out = ref_r;
endmodule // reference_shaper

`default_nettype wire

// [logic/dead_time_unit.sv]
/*
 Dead-time insertion for one primary/paired output pair.
 Assumes tick is a one-cycle strobe per dead-time clock period.
*/
`timescale 1ns/1ps
`default_nettype none

module dead_time_unit
    import shaping_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic rst,
    chan_if.unit      ch
);
    dt_state_t   state_r;
    dt_state_t   state_nxt;
    logic [10:0] cnt_r;
    logic [10:0] cnt_nxt;
    logic        pri_r;
    logic        pri_nxt;
    logic        pair_r;
    logic        pair_nxt;

    ////////////////////////////////////////////////////////////////////////
    // In complementary mode both outputs stay off while a wait runs, so the pair never overlaps
    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        case (state_r)
            ST_LOW:
                if (ch.ref_in)
                begin
                    if (ch.dt_en && ch.rise_ticks != 11'h000)
                    begin
                        state_nxt = ST_RISE_WAIT;
                        cnt_nxt   = ch.rise_ticks;
                    end
                    else
                        state_nxt = ST_HIGH;
                end
            ST_RISE_WAIT:
                if (!ch.ref_in)
                    state_nxt = ST_LOW;
                else if (!ch.dt_en || (ch.tick && cnt_r == DT_ONE))
                    state_nxt = ST_HIGH;
                else if (ch.tick)
                    cnt_nxt = cnt_r - DT_ONE;
            ST_HIGH:
                if (!ch.ref_in)
                begin
                    if (ch.dt_en && ch.fall_ticks != 11'h000)
                    begin
                        state_nxt = ST_FALL_WAIT;
                        cnt_nxt   = ch.fall_ticks;
                    end
                    else
                        state_nxt = ST_LOW;
                end
            default:
                if (ch.ref_in || !ch.dt_en || (ch.tick && cnt_r == DT_ONE))
                    state_nxt = ST_LOW;
                else if (ch.tick)
                    cnt_nxt = cnt_r - DT_ONE;
        endcase
        pri_nxt  = !ch.brk && state_nxt == ST_HIGH;
        pair_nxt = !ch.brk && (ch.comp ? state_nxt == ST_LOW
                                       : ch.pair_ref);
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            state_r <= ST_LOW;
            cnt_r   <= 11'h000;
            pri_r   <= 1'b0;
            pair_r  <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            pri_r   <= pri_nxt;
            pair_r  <= pair_nxt;
        end
    end

    assign ch.pri  = pri_r;
    assign ch.pair = pair_r;
endmodule // dead_time_unit

`default_nettype wire

// [logic/timer_output_shaping.sv]
/*
 Output shaping of the four compare channels: register pair, reference
 shaping, pairing, break gating and dead-time insertion.
 Assumes the counter, compare logic, shared protection register and the
 dead-time tick generator sit outside and are synchronous to clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none

module timer_output_shaping
    import shaping_pkg::*;
#(
    parameter int NUM_CHAN = NUM_CH
)
(
    input  wire logic              clk_sys,
    input  wire logic              rst,
    input  wire logic [7:0]        reg_addr,
    input  wire logic              reg_wr_en,
    input  wire logic              reg_rd_en,
    input  wire logic [31:0]       reg_wdata,
    output logic      [31:0]       reg_rdata,
    input  wire logic [1:0]        protection_level,
    input  wire logic [7:0]        shared_dead_time_code,
    input  wire logic              shared_run_off_state,
    input  wire logic              shared_idle_off_state,
    input  wire logic              dt_tick,
    input  wire logic              count_down,
    input  wire logic [NUM_CHAN-1:0] cmp_ref,
    input  wire logic [NUM_CHAN-1:0] cmp_match,
    input  wire logic [NUM_CHAN-1:0] add_match,
    input  wire logic [NUM_CHAN-1:0] paired_ref,
    input  wire logic              break_in,
    output logic      [NUM_CHAN-1:0] primary_out,
    output logic      [NUM_CHAN-1:0] paired_out,
    output logic      [NUM_CHAN-1:0] paired_input_en,
    output logic                   quad_loss_detect_en,
    output logic                   quad_double_toggle_detect_en,
    output logic                   run_off_state_0,
    output logic                   idle_off_state_0
);

    ////////////////////////////////////////////////////////////////////////
    // Field layout is fixed at four channels
    if (NUM_CHAN != NUM_CH)
    begin : g_bad_chan
        $error("timer_output_shaping supports exactly four channels");
    end

    logic [31:0]  ctl_r;
    logic [31:0]  ctl_nxt;
    logic [31:0]  ovr_r;
    logic [31:0]  ovr_nxt;
    logic [31:0]  rdata_r;
    logic [31:0]  rdata_nxt;
    logic [31:0]  ovr_wmask;
    logic [NUM_CHAN-1:0] shaped_ref;
    logic [NUM_CHAN-1:0] composite_pwm_en;
    logic [NUM_CHAN-1:0] break_en;
    logic [NUM_CHAN-1:0] dead_time_insert_en;
    pair_mode_t   pair_select [NUM_CHAN];
    match_pulse_t match_pulse_select [NUM_CHAN];
    logic [10:0]  rise_ticks [NUM_CHAN];
    logic         override_select_0;

    ////////////////////////////////////////////////////////////////////////
    // Register writes; reserved bits are never stored and read as zero
    always_comb
    begin
        ctl_nxt   = ctl_r;
        ovr_nxt   = ovr_r;
        // Lock fields only open at level 00, off-states unless 1x
        ovr_wmask = ((protection_level == PROT_OPEN) ? OVR_OPEN_MASK
                                                      : 32'h0000_0000)
                  | (protection_level[1] ? 32'h0000_0000 : OVR_STATE_MASK);
        if (reg_wr_en && reg_addr == CTL_OFFSET)
            ctl_nxt = reg_wdata & CTL_WMASK;
        else if (reg_wr_en && reg_addr == OVR_OFFSET)
            ovr_nxt = (ovr_r & ~ovr_wmask) | (reg_wdata & ovr_wmask);
    end

    // Registered read data, unmapped addresses answer zero
    always_comb
    begin
        rdata_nxt = rdata_r;
        if (reg_rd_en && reg_addr == CTL_OFFSET)
            rdata_nxt = ctl_r;
        else if (reg_rd_en && reg_addr == OVR_OFFSET)
            rdata_nxt = ovr_r;
        else if (reg_rd_en)
            rdata_nxt = 32'h0000_0000;
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            ctl_r   <= CTL_RESET;
            ovr_r   <= OVR_RESET;
            rdata_r <= 32'h0000_0000;
        end
        else
        begin
            ctl_r   <= ctl_nxt;
            ovr_r   <= ovr_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata = rdata_r;

    ////////////////////////////////////////////////////////////////////////
    // Field extraction and channel 0 setting source
    assign quad_loss_detect_en          = ctl_r[QLOSS_BIT];
    assign quad_double_toggle_detect_en = ctl_r[QJUMP_BIT];
    assign override_select_0            = ovr_r[OVR_SEL_BIT];
    // Shared settings serve channel 0 unless the override is selected
    assign run_off_state_0  = override_select_0 ? ovr_r[OVR_ROS_BIT]
                                                : shared_run_off_state;
    assign idle_off_state_0 = override_select_0 ? ovr_r[OVR_IOS_BIT]
                                                : shared_idle_off_state;

    ////////////////////////////////////////////////////////////////////////
    // One shaper and one dead-time unit per channel
    for (genvar i = 0; i < NUM_CHAN; i++)
    begin : g_ch
        chan_if ch ();
        logic [7:0] rise_code;
        logic [7:0] fall_code;

        assign composite_pwm_en[i]    = ctl_r[CPWM_LSB + i];
        assign pair_select[i]         =
            pair_mode_t'(ctl_r[PSEL_LSB + 2*i +: 2]);
        assign match_pulse_select[i]  =
            match_pulse_t'(ctl_r[MPSEL_LSB + 2*i +: 2]);
        assign break_en[i]            = ctl_r[BRK_LSB + i];
        assign dead_time_insert_en[i] = ctl_r[DTI_LSB + i];
        // Paired input only listens when not complementary
        assign paired_input_en[i]     = pair_select[i] != PAIR_COMP;

        // Only channel 0 has its own override settings
        assign rise_code = (i == 0 && override_select_0)
                         ? ovr_r[OVR_RISE_LSB +: 8] : shared_dead_time_code;
        assign fall_code = (i == 0 && override_select_0)
                         ? ovr_r[OVR_FALL_LSB +: 8]
                         : shared_dead_time_code;
        assign rise_ticks[i] = dt_ticks(rise_code);

        reference_shaper u_shaper (
            .clk_sys      (clk_sys),
            .rst          (rst),
            .normal_ref   (cmp_ref[i]),
            .match        (cmp_match[i]),
            .add_match    (add_match[i]),
            .count_down   (count_down),
            .composite_en (composite_pwm_en[i]),
            .sel          (match_pulse_select[i]),
            .ref_out      (shaped_ref[i])
        );

        assign ch.ref_in     = shaped_ref[i];
        assign ch.pair_ref   = paired_ref[i];
        // Reserved codes behave as independent
        assign ch.comp       = pair_select[i] == PAIR_COMP;
        assign ch.dt_en      = dead_time_insert_en[i];
        assign ch.brk        = break_in && break_en[i];
        assign ch.tick       = dt_tick;
        assign ch.rise_ticks = rise_ticks[i];
        assign ch.fall_ticks = dt_ticks(fall_code);

        dead_time_unit u_dt (
            .clk_sys (clk_sys),
            .rst     (rst),
            .ch      (ch)
        );

        assign primary_out[i] = ch.pri;
        assign paired_out[i]  = ch.pair;
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks on channel 0 and on the register pair
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    ovr_lock_hold_a:
    assert property (reg_wr_en && reg_addr == OVR_OFFSET
                     && protection_level != PROT_OPEN
                     |=> ovr_r[31] == $past(ovr_r[31])
                         && ovr_r[23:16] == $past(ovr_r[23:16]))
    else $error("locked override field changed");

    quad_enables_a:
    assert property (reg_wr_en && reg_addr == CTL_OFFSET
                     |=> quad_loss_detect_en == $past(reg_wdata[19])
                         && quad_double_toggle_detect_en
                            == $past(reg_wdata[18]))
    else $error("quadrature enables do not follow write");

    cpwm_bits_a:
    assert property (reg_wr_en && reg_addr == CTL_OFFSET
                     |=> composite_pwm_en == $past(reg_wdata[31:28]))
    else $error("composite enables do not follow write");

    composite_set_a:
    assert property (composite_pwm_en[0] && cmp_match[0]
                     && match_pulse_select[0] == MP_NORMAL
                     |=> shaped_ref[0])
    else $error("main match did not set composite level");

    composite_clear_a:
    assert property (composite_pwm_en[0] && add_match[0] && !cmp_match[0]
                     && match_pulse_select[0] == MP_NORMAL
                     |=> !shaped_ref[0])
    else $error("additional match did not clear composite level");

    pulse_up_a:
    assert property (match_pulse_select[0] == MP_UP
                     |=> shaped_ref[0] == $past(cmp_match[0] && !count_down))
    else $error("up-count match pulse wrong");

    pulse_down_a:
    assert property (match_pulse_select[0] == MP_DOWN
                     |=> shaped_ref[0] == $past(cmp_match[0] && count_down))
    else $error("down-count match pulse wrong");

    pulse_both_a:
    assert property (match_pulse_select[0] == MP_BOTH && !cmp_match[0]
                     ##1 match_pulse_select[0] == MP_BOTH && cmp_match[0]
                     |=> shaped_ref[0]
                         ##1 ($past(match_pulse_select[0]) != MP_BOTH
                              || shaped_ref[0] == $past(cmp_match[0])))
    else $error("two-way match pulse wrong");

    normal_ref_a:
    assert property (match_pulse_select[0] == MP_NORMAL
                     && !composite_pwm_en[0]
                     |=> shaped_ref[0] == $past(cmp_ref[0]))
    else $error("normal reference not passed");

    comp_pair_a:
    assert property (pair_select[0] == PAIR_COMP && !dead_time_insert_en[0]
                     && !(break_in && break_en[0])
                     |=> paired_out[0] == !primary_out[0])
    else $error("complementary outputs not opposite");

    indep_pair_a:
    assert property (pair_select[0] == PAIR_INDEP
                     && !(break_in && break_en[0])
                     |=> paired_out[0] == $past(paired_ref[0]))
    else $error("independent paired output wrong");

    no_overlap_a:
    assert property (pair_select[0] == PAIR_COMP
                     |=> !(primary_out[0] && paired_out[0]))
    else $error("complementary outputs overlap");

    break_off_a:
    assert property (break_in && break_en[0]
                     |=> !primary_out[0] && !paired_out[0])
    else $error("break did not force outputs off");

    override_src_a:
    assert property (override_select_0
                     |-> run_off_state_0 == ovr_r[11]
                         && idle_off_state_0 == ovr_r[10])
    else $error("override settings not selected");

    code_short_a:
    assert property (!override_select_0 && !shared_dead_time_code[7]
                     |-> rise_ticks[0] == {3'h0, shared_dead_time_code})
    else $error("dead-time code 0xx wrong");

    code_double_a:
    assert property (shared_dead_time_code[7:6] == 2'h2
                     && !override_select_0
                     |-> rise_ticks[0] == 11'd2 * (11'd64
                         + {5'h00, shared_dead_time_code[5:0]}))
    else $error("dead-time code 10x wrong");

    code_eight_a:
    assert property (shared_dead_time_code[7:5] == 3'h6
                     && !override_select_0
                     |-> rise_ticks[0] == 11'd8 * (11'd32
                         + {6'h00, shared_dead_time_code[4:0]}))
    else $error("dead-time code 110 wrong");

    code_sixteen_a:
    assert property (shared_dead_time_code[7:5] == 3'h7
                     && !override_select_0
                     |-> rise_ticks[0] == 11'd16 * (11'd32
                         + {6'h00, shared_dead_time_code[4:0]}))
    else $error("dead-time code 111 wrong");

    // Main scenarios worth seeing
    cover_dt_rise: cover property (pair_select[0] == PAIR_COMP
                     && dead_time_insert_en[0] && !primary_out[0]
                     && !paired_out[0] ##1 primary_out[0]);
    cover_break: cover property (break_in && break_en[0] && primary_out[0]);
    cover_pulse_up: cover property (match_pulse_select[0] == MP_UP
                     && shaped_ref[0]);
    cover_ovr_write: cover property (reg_wr_en && reg_addr == OVR_OFFSET
                     && protection_level == PROT_OPEN ##1 override_select_0);

endmodule // timer_output_shaping

`default_nettype wire

// [bench/gate_driver_model.sv]
/* Gate drivers of four switch legs.
   Assumes outputs settle before each clk_sys edge. */
`timescale 1ns/1ps
`default_nettype none
module gate_driver_model
(
    input  wire logic       clk_sys,
    input  wire logic [3:0] high_on,
    input  wire logic [3:0] low_on,
    output int              overlap_cnt
);
    int cnt_r = 0;

    // Both switches of one leg on would short the supply
    always @(posedge clk_sys)
        if ((high_on & low_on) != 4'h0)
            cnt_r <= cnt_r + 1;
    assign overlap_cnt = cnt_r;
endmodule // gate_driver_model
`default_nettype wire

// [bench/timer_output_shaping_tb.sv]
/* Self-checking bench for the output shaping block.
   Assumes tick every cycle; off-state inputs tied low. */
`timescale 1ns/1ps
`default_nettype none
module timer_output_shaping_tb;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic        reg_wr_en = 1'b0;
    logic        reg_rd_en = 1'b0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic [1:0]  prot = 2'h0;
    logic [7:0]  dt_code = 8'h00;
    logic        count_down = 1'b0, break_in = 1'b0;
    logic [3:0]  cmp_ref = 4'h0, cmp_match = 4'h0, pri, par, pin;
    logic        qloss, qjump, ros0;
    logic [3:0]  pref = 4'h0, add_m = 4'h0;
    int          err_total = 0, check_count = 0, cyc = 0, ovl;

    timer_output_shaping u_timer_output_shaping (.clk_sys, .rst,
        .reg_addr, .reg_wr_en, .reg_rd_en, .reg_wdata, .reg_rdata,
        .protection_level(prot), .shared_dead_time_code(dt_code),
        .shared_run_off_state(1'b0), .shared_idle_off_state(1'b0),
        .dt_tick(1'b1), .count_down, .cmp_ref, .cmp_match,
        .add_match(add_m), .paired_ref(pref), .break_in,
        .primary_out(pri), .paired_out(par), .paired_input_en(pin),
        .quad_loss_detect_en(qloss), .run_off_state_0(ros0),
        .quad_double_toggle_detect_en(qjump), .idle_off_state_0());
    gate_driver_model u_gate_driver_model (.clk_sys,
        .high_on(pri), .low_on(par), .overlap_cnt(ovl));

    ////////////////////////////////////////////////////////////
    // Clock, and a ceiling on run time in case of a hang
    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            give_verdict();
        end
    end

    task give_verdict();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task chk(input string n, input logic [31:0] e, input logic [31:0] s);
        check_count++;
        if (s !== e)
        begin
            $display("[FAIL] %s exp %h got %h", n, e, s);
            err_total++;
        end
    endtask

    // Word write; strobe held for exactly one edge
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr_en <= 1'b1;
        @(posedge clk_sys);
        reg_wr_en <= 1'b0;
    endtask

    // Read, then judge the registered data one cycle later
    task rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd_en <= 1'b1;
        @(posedge clk_sys);
        reg_rd_en <= 1'b0;
        @(posedge clk_sys);
        #1;
        chk("rdata", e, reg_rdata);
    endtask

    ////////////////////////////////////////////////////////////
    task t_reset_ctl();
        rd(8'h74, 32'h0FF0_00FF);
        rd(8'h7C, 32'h0);
        chk("pair_in", 4'h0, pin);
        wr(8'h74, 32'h0004_0000);
        rd(8'h74, 32'h0004_0000);
        chk("qloss", 1'b0, qloss);
        chk("qjump", 1'b1, qjump);
        chk("pair_in", 4'hF, pin);
        @(posedge clk_sys);
        pref <= 4'h1;
        repeat (2) @(posedge clk_sys);
        #1;
        chk("par_ind", 4'h1, par);
        @(posedge clk_sys);
        pref <= 4'h0;
    endtask

    // Locked level first, so a stored value proves the gate opened
    task t_lock();
        @(posedge clk_sys);
        prot <= 2'h1;
        wr(8'h7C, 32'h80FF_0C00);
        rd(8'h7C, 32'h0000_0C00);
        @(posedge clk_sys);
        prot <= 2'h0;
        wr(8'h7C, 32'h80FF_0C00);
        rd(8'h7C, 32'h80FF_0C00);
        chk("ros0", 1'b1, ros0);
        wr(8'h7C, 32'h0);
    endtask

    task t_pulse();
        int n;
        for (int s = 1; s < 4; s++)
            for (int d = 0; d < 2; d++)
            begin
                wr(8'h74, 32'(s) << 8);
                @(posedge clk_sys);
                count_down <= d[0];
                cmp_match <= 4'h1;
                @(posedge clk_sys);
                cmp_match <= 4'h0;
                n = 0;
                repeat (6)
                begin
                    @(posedge clk_sys);
                    #1;
                    n += pri[0];
                end
                chk("pulse", (s >> d) & 1, n);
            end
    endtask

    // Composite: set by main match, cleared by additional match
    task t_comp();
        wr(8'h74, 32'h1000_0000);
        @(posedge clk_sys);
        cmp_match <= 4'h1;
        @(posedge clk_sys);
        cmp_match <= 4'h0;
        repeat (3) @(posedge clk_sys);
        #1;
        chk("cpwm_set", 1'b1, pri[0]);
        @(posedge clk_sys);
        add_m <= 4'h1;
        @(posedge clk_sys);
        add_m <= 4'h0;
        repeat (3) @(posedge clk_sys);
        #1;
        chk("cpwm_clr", 1'b0, pri[0]);
    endtask

    // One code per formula branch; longest wait 512 ticks
    task automatic t_dead();
        int n;
        int e[4] = '{3, 130, 264, 512};
        logic [7:0] c[4] = '{8'h03, 8'h81, 8'hC1, 8'hE0};
        wr(8'h74, 32'h0030_0001);
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk_sys);
            dt_code <= c[i];
            cmp_ref <= 4'h0;
            repeat (600) @(posedge clk_sys);
            cmp_ref <= 4'h1;
            n = 0;
            while (par[0] !== 1'b0 && n < 20)
            begin
                @(posedge clk_sys);
                #1;
                n++;
            end
            n = 0;
            while (pri[0] !== 1'b1 && n < 1000)
            begin
                @(posedge clk_sys);
                #1;
                n++;
            end
            chk("dead", e[i], n);
        end
    endtask

    // Complementary pair, break enabled, no dead time
    task t_break();
        wr(8'h74, 32'h0030_0010);
        repeat (4) @(posedge clk_sys);
        #1;
        chk("pri_on", 1'b1, pri[0]);
        chk("par_comp", 1'b0, par[0]);
        @(posedge clk_sys);
        break_in <= 1'b1;
        @(posedge clk_sys);
        #1;
        chk("pri_brk", 1'b0, pri[0]);
        @(posedge clk_sys);
        break_in <= 1'b0;
    endtask

    // Main sequence
    initial
    begin
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        t_reset_ctl();
        t_lock();
        t_pulse();
        t_comp();
        t_dead();
        t_break();
        chk("overlap", 0, ovl);
        give_verdict();
    end
endmodule // timer_output_shaping_tb
`default_nettype wire
